// ===== btu_core.sv
// bit test execution unit: decode, operand fetch, flag update and set write-back
//
// Contract
// [RQ1] memory test opcode AB, position bits high, 13-bit address mid, bit 0 shared
// [RQ2] memory test puts the inverted selected bit into the nil flag
// [RQ3] memory test never writes memory; only the nil flag changes
// [RQ4] byte addresses up to 8191; word addresses even, up to 8190
// [RQ5] bit 0 is least significant, up to 7 for bytes, 15 for words
// [RQ6] software keeps word addresses aligned and byte positions within 0..7
// [RQ7] byte size only with the byte suffix, otherwise word size
// [RQ8] carry destination copies the bit; nil destination stores its inverse
// [RQ9] missing destination suffix means nil destination
// [RQ10] register tests are word sized, positions 0..15, source value kept
// [RQ11] operand direct or indirect in five forms, 3-bit mode, 4-bit register
// [RQ12] literal form takes the position from its 4-bit field
// [RQ13] indexed form uses only the low four bits of the index register
// [RQ14] indexed form: destination bit then 4-bit index register field
// [RQ15] test-then-set opcode AC, same field layout as memory test
// [RQ16] test-then-set loads inverted bit into nil flag, then sets the bit
// [RQ17] software never aims test-then-set at the flags register
// [RQ18] one instruction per cycle, longer only for slow memory reads
// [RQ19] instruction address drives the read and the test-then-set write-back
// [RQ20] pointer updates step by two
// [RQ21] carry at bit 0, nil at bit 1, other flags untouched
`timescale 1ns/1ps
`default_nettype none
module btu_core (
	// clock and reset
	input wire logic i_clk,
	input wire logic i_rst_n,
	// instruction
	input wire logic i_instr_valid,
	input wire logic [23:0] i_instr,
	input wire logic i_byte_sfx,
	// data memory
	output logic o_mem_rd_en,
	output logic [15:0] o_mem_rd_addr,
	input wire logic [15:0] i_mem_rd_data,
	input wire logic i_mem_wait,
	output btu_pkg::btu_wr_t o_mem_wr,
	// working registers
	input wire logic i_wreg_wr_en,
	input wire logic [3:0] i_wreg_wr_sel,
	input wire logic [15:0] i_wreg_wr_data,
	input wire logic [3:0] i_wreg_rd_sel,
	output logic [15:0] o_wreg_rd_data,
	// flags register
	input wire logic i_flags_wr_en,
	input wire logic [15:0] i_flags_wr_data,
	output logic [15:0] o_flags,
	// status
	output logic o_done,
	output logic o_illegal
);

	btu_pkg::btu_state_t r;
	btu_pkg::btu_state_t n;
	logic stall;
	logic acc;
	logic fin;
	logic dec_ok;
	logic tbit;
	logic [15:0] set_word;
	logic [15:0] opnd;
	logic [7:0] opc;
	logic [2:0] mode;
	logic [3:0] src_sel;
	logic [3:0] idx_sel;
	logic [15:0] ptr;
	logic [15:0] ea;

	// pointer moved by one word up or down
	function automatic logic [15:0] btu_step(input logic [15:0] p, input logic up);
		if (up) begin
			btu_step = p + btu_pkg::BTU_PTR_STEP; // [RQ20]
		end else begin
			btu_step = p - btu_pkg::BTU_PTR_STEP; // [RQ20]
		end
	endfunction : btu_step

	// true for the two memory-operand opcodes
	function automatic logic btu_is_mem(input logic [7:0] code);
		btu_is_mem = (code == btu_pkg::BTU_OPC_MEM_TEST) || (code == btu_pkg::BTU_OPC_MEM_SET);
	endfunction : btu_is_mem

	// true for the two working-register opcodes
	function automatic logic btu_is_wreg(input logic [7:0] code);
		btu_is_wreg = (code == btu_pkg::BTU_OPC_WREG_LIT) || (code == btu_pkg::BTU_OPC_WREG_IDX);
	endfunction : btu_is_wreg

	// handshake terms of the two stages
	assign stall = r.ex.valid && r.ex.use_mem && i_mem_wait; // [RQ18]
	assign acc = i_instr_valid && !stall;
	assign fin = r.ex.valid && !stall;
	assign opnd = r.ex.use_mem ? i_mem_rd_data : r.ex.opnd;
	assign opc = i_instr[btu_pkg::BTU_OPC_LSB +: 8];
	assign mode = i_instr[btu_pkg::BTU_MODE_LSB +: 3]; // [RQ11]
	assign src_sel = i_instr[btu_pkg::BTU_SRC_LSB +: 4]; // [RQ11]
	assign idx_sel = i_instr[btu_pkg::BTU_IDX_REG_LSB +: 4]; // [RQ14]
	assign ptr = r.wreg[src_sel];

	// bit picked from the execute stage operand
	btu_bitsel u_bitsel (
		.i_word(opnd),
		.i_idx(r.ex.idx),
		.i_byte_op(r.ex.byte_op),
		.i_byte_hi(r.ex.addr[0]),
		.o_bit(tbit),
		.o_set_word(set_word)
	);

	// next state: loads, execute stage, then decode stage
	always_comb begin
		n = r;
		n.done = 1'b0;
		n.illegal = 1'b0;
		n.wr.en = 1'b0;
		n.rd_en = 1'b0;
		dec_ok = 1'b0;
		ea = ptr;
		n.wreg_rd = r.wreg[i_wreg_rd_sel];
		if (i_wreg_wr_en) begin
			n.wreg[i_wreg_wr_sel] = i_wreg_wr_data;
		end
		if (i_flags_wr_en) begin
			n.flags = i_flags_wr_data;
		end
		// execute: slow reads hold the stage and the read request
		if (stall) begin
			n.rd_en = r.rd_en; // [RQ18]
		end else if (r.ex.valid) begin
			n.done = 1'b1;
			n.ex.valid = 1'b0;
			if (r.ex.dest_nil) begin
				n.flags[btu_pkg::BTU_FLAG_NIL] = !tbit; // [RQ2] [RQ8] [RQ16] [RQ21]
			end else begin
				n.flags[btu_pkg::BTU_FLAG_CARRY] = tbit; // [RQ8] [RQ21]
			end
			// only test-then-set writes back; a plain test leaves memory alone
			if (r.ex.kind == btu_pkg::BTU_K_MEM_SET) begin // [RQ3]
				n.wr.en = 1'b1;
				n.wr.addr = r.ex.addr; // [RQ19]
				n.wr.data = r.ex.byte_op ? {set_word[15:8], set_word[7:0]} : set_word;
				if (!r.ex.byte_op) begin
					n.wr.be = btu_pkg::BTU_BE_WORD;
				end else if (r.ex.addr[0]) begin
					n.wr.be = btu_pkg::BTU_BE_HI;
				end else begin
					n.wr.be = btu_pkg::BTU_BE_LO;
				end
			end
		end else begin
			n.ex.valid = 1'b0;
		end
		// decode and operand fetch
		if (acc) begin
			dec_ok = 1'b1;
			n.ex.opnd = 16'h0000;
			case (opc)
				btu_pkg::BTU_OPC_MEM_TEST,
				btu_pkg::BTU_OPC_MEM_SET: begin // [RQ1] [RQ15]
					n.ex.kind = (opc == btu_pkg::BTU_OPC_MEM_SET) ? btu_pkg::BTU_K_MEM_SET : btu_pkg::BTU_K_MEM_TEST;
					n.ex.byte_op = i_byte_sfx; // [RQ7]
					n.ex.dest_nil = 1'b1;
					n.ex.use_mem = 1'b1;
					if (i_byte_sfx) begin
						// byte: shared bit is the address LSB, picks the lane
						n.ex.addr = {3'h0, i_instr[btu_pkg::BTU_MEM_ADDR_MSB:btu_pkg::BTU_SHARED_POS]}; // [RQ1] [RQ4]
						n.ex.idx = {1'b0, i_instr[btu_pkg::BTU_MEM_POS_LSB +: 3]}; // [RQ5]
					end else begin
						// word: address even, shared bit is the position LSB
						n.ex.addr = {3'h0, i_instr[btu_pkg::BTU_MEM_ADDR_MSB:btu_pkg::BTU_MEM_ADDR_LSB], 1'b0}; // [RQ1] [RQ6]
						n.ex.idx = {i_instr[btu_pkg::BTU_MEM_POS_LSB +: 3], i_instr[btu_pkg::BTU_SHARED_POS]}; // [RQ1]
					end
					n.rd_en = 1'b1;
					n.rd_addr = n.ex.addr; // [RQ19]
				end
				btu_pkg::BTU_OPC_WREG_LIT,
				btu_pkg::BTU_OPC_WREG_IDX: begin
					n.ex.kind = btu_pkg::BTU_K_WREG;
					n.ex.byte_op = 1'b0; // [RQ10]
					if (opc == btu_pkg::BTU_OPC_WREG_LIT) begin
						n.ex.idx = i_instr[btu_pkg::BTU_LIT_POS_LSB +: 4]; // [RQ12]
						n.ex.dest_nil = i_instr[btu_pkg::BTU_LIT_DEST_POS]; // [RQ8] [RQ9]
					end else begin
						n.ex.idx = r.wreg[idx_sel][3:0]; // [RQ13]
						n.ex.dest_nil = i_instr[btu_pkg::BTU_IDX_DEST_POS]; // [RQ9] [RQ14]
					end
					n.ex.use_mem = 1'b1;
					case (mode)
						btu_pkg::BTU_AM_DIRECT: begin
							n.ex.use_mem = 1'b0;
							n.ex.opnd = ptr; // [RQ10]
						end
						btu_pkg::BTU_AM_IND: begin
							ea = ptr; // [RQ11]
						end
						btu_pkg::BTU_AM_POSTINC: begin
							n.wreg[src_sel] = btu_step(ptr, 1'b1); // [RQ11] [RQ20]
						end
						btu_pkg::BTU_AM_POSTDEC: begin
							n.wreg[src_sel] = btu_step(ptr, 1'b0); // [RQ11] [RQ20]
						end
						btu_pkg::BTU_AM_PREINC: begin
							ea = btu_step(ptr, 1'b1); // [RQ11]
							n.wreg[src_sel] = ea;
						end
						btu_pkg::BTU_AM_PREDEC: begin
							ea = btu_step(ptr, 1'b0); // [RQ11]
							n.wreg[src_sel] = ea;
						end
						default: begin
							dec_ok = 1'b0;
						end
					endcase
					n.ex.addr = ea;
					n.rd_en = n.ex.use_mem && dec_ok;
					n.rd_addr = ea;
				end
				default: begin
					dec_ok = 1'b0;
				end
			endcase
			if (dec_ok) begin
				n.ex.valid = 1'b1;
			end else begin
				n.illegal = 1'b1;
				n.ex.valid = 1'b0;
				n.rd_en = 1'b0;
				n.wreg = r.wreg;
				if (i_wreg_wr_en) begin
					n.wreg[i_wreg_wr_sel] = i_wreg_wr_data;
				end
			end
		end
	end

	// state register with synchronous reset
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			r <= btu_pkg::BTU_STATE_RST;
		end else begin
			r <= n;
		end
	end

	// outputs straight from the state flops
	assign o_mem_rd_en = r.rd_en;
	assign o_mem_rd_addr = r.rd_addr;
	assign o_mem_wr = r.wr;
	assign o_wreg_rd_data = r.wreg_rd;
	assign o_flags = r.flags;
	assign o_done = r.done;
	assign o_illegal = r.illegal;

	// helper terms watched by the checks below
	logic acc_mem_word;
	logic acc_direct_lit;
	logic acc_postinc;
	logic [11:0] instr_addr_hi;
	logic [13:0] flags_hi;
	logic [15:0] ptr_plus;
	logic [3:0] idx_low;
	assign acc_mem_word = acc && !i_byte_sfx && btu_is_mem(opc);
	assign acc_direct_lit = acc && opc == btu_pkg::BTU_OPC_WREG_LIT && mode == btu_pkg::BTU_AM_DIRECT;
	assign acc_postinc = acc && opc == btu_pkg::BTU_OPC_WREG_LIT && mode == btu_pkg::BTU_AM_POSTINC;
	assign instr_addr_hi = i_instr[12:1];
	assign flags_hi = r.flags[15:2];
	assign ptr_plus = r.wreg[src_sel] + 16'h0002;
	assign idx_low = r.wreg[idx_sel][3:0];

	// terms for the byte, pre-decrement, literal and refusal checks
	logic acc_mem_byte;
	logic acc_predec;
	logic acc_lit;
	logic acc_bad;
	logic [12:0] instr_addr_all;
	logic [3:0] instr_lit_pos;
	logic [15:0] ptr_minus;
	assign acc_mem_byte = acc && i_byte_sfx && btu_is_mem(opc);
	assign acc_predec = acc && btu_is_wreg(opc) && mode == btu_pkg::BTU_AM_PREDEC;
	assign acc_lit = acc && dec_ok && opc == btu_pkg::BTU_OPC_WREG_LIT;
	assign acc_bad = acc && !dec_ok;
	assign instr_addr_all = i_instr[btu_pkg::BTU_MEM_ADDR_MSB:btu_pkg::BTU_SHARED_POS];
	assign instr_lit_pos = i_instr[btu_pkg::BTU_LIT_POS_LSB +: 4];
	assign ptr_minus = r.wreg[src_sel] - 16'h0002;

	default clocking btu_cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_n);

	AST_MEM_WORD_ADDR: assert property (acc_mem_word |=> o_mem_rd_en && o_mem_rd_addr[0] == 1'b0 // [RQ1]
		&& o_mem_rd_addr[12:1] == $past(instr_addr_hi) && o_mem_rd_addr[15:13] == 3'h0)
		else $error("word memory test read address wrong");
	AST_TEST_NO_WRITE: assert property (fin && r.ex.kind == btu_pkg::BTU_K_MEM_TEST |=> !o_mem_wr.en && o_done) // [RQ3]
		else $error("plain memory test wrote memory");
	AST_NIL_INVERT: assert property (fin && r.ex.dest_nil |=> o_flags[1] == !$past(tbit)) // [RQ2]
		else $error("nil flag not the inverted bit");
	AST_CARRY_COPY: assert property (fin && !r.ex.dest_nil && !i_flags_wr_en // [RQ8]
		|=> o_flags[0] == $past(tbit) && o_flags[1] == $past(o_flags[1]))
		else $error("carry flag not the tested bit");
	AST_FLAGS_KEPT: assert property (fin && !i_flags_wr_en |=> o_flags[15:2] == $past(flags_hi)) // [RQ21]
		else $error("unrelated flags changed");
	AST_SET_WRITE: assert property (fin && r.ex.kind == btu_pkg::BTU_K_MEM_SET // [RQ16]
		|=> o_mem_wr.en && o_mem_wr.addr == $past(r.ex.addr) && o_flags[1] == !$past(tbit) && o_done)
		else $error("test-then-set write-back missing");
	AST_ONE_CYCLE: assert property (acc && dec_ok ##1 !i_mem_wait |=> o_done) // [RQ18]
		else $error("instruction took more than one cycle");
	AST_PTR_STEP: assert property (acc_postinc && !i_wreg_wr_en |=> r.wreg[$past(src_sel)] == $past(ptr_plus)) // [RQ20]
		else $error("post-increment did not step by two");
	AST_IDX_LOW: assert property (acc && opc == btu_pkg::BTU_OPC_WREG_IDX && dec_ok // [RQ13]
		|=> r.ex.idx == $past(idx_low))
		else $error("index not from low four bits");
	AST_SRC_KEPT: assert property (acc_direct_lit && !i_wreg_wr_en |=> r.wreg == $past(r.wreg) && !o_mem_rd_en) // [RQ10]
		else $error("direct test altered registers");

	// addressing, byte lanes, slow reads and refusals
	AST_MEM_BYTE_ADDR: assert property (acc_mem_byte |=> o_mem_rd_en // [RQ4]
		&& o_mem_rd_addr == {3'h0, $past(instr_addr_all)})
		else $error("byte memory test read address wrong");
	AST_BYTE_LANE: assert property (fin && r.ex.kind == btu_pkg::BTU_K_MEM_SET && r.ex.byte_op // [RQ7]
		|=> o_mem_wr.be == ($past(r.ex.addr[0]) ? btu_pkg::BTU_BE_HI : btu_pkg::BTU_BE_LO))
		else $error("byte write-back on the wrong lane");
	AST_SET_ONE_BIT: assert property (fin && r.ex.kind == btu_pkg::BTU_K_MEM_SET // [RQ16]
		|=> ($past(opnd) & ~o_mem_wr.data) == 16'h0000 && $onehot0(o_mem_wr.data ^ $past(opnd)))
		else $error("write-back changed more than the tested bit");
	AST_PREDEC_ADDR: assert property (acc_predec |=> o_mem_rd_en && o_mem_rd_addr == $past(ptr_minus) // [RQ11]
		&& r.wreg[$past(src_sel)] == $past(ptr_minus))
		else $error("pre-decrement address or pointer wrong");
	AST_STALL_HOLD: assert property (stall |=> o_mem_rd_en && !o_done // [RQ18]
		&& o_mem_rd_addr == $past(o_mem_rd_addr))
		else $error("slow read not held");
	AST_ILLEGAL_QUIET: assert property (acc_bad && !i_wreg_wr_en // [RQ11]
		|=> o_illegal && !o_mem_rd_en && !r.ex.valid && r.wreg == $past(r.wreg))
		else $error("refused instruction had an effect");
	AST_LIT_POS: assert property (acc_lit |=> r.ex.idx == $past(instr_lit_pos)) // [RQ12]
		else $error("literal position not taken from its field");
	AST_FLAGS_QUIET: assert property (!fin && !i_flags_wr_en |=> o_flags == $past(o_flags)) // [RQ21]
		else $error("flags changed with no instruction finishing");
	AST_DONE_CAUSE: assert property (o_done |-> $past(fin)) // [RQ18]
		else $error("completion without a finishing instruction");

	COV_MEM_SET: cover property (fin && r.ex.kind == btu_pkg::BTU_K_MEM_SET ##1 o_mem_wr.en);
	COV_IDX_CARRY: cover property (fin && r.ex.kind == btu_pkg::BTU_K_WREG && !r.ex.dest_nil);
	COV_STALL: cover property (stall ##1 fin);
	COV_ILLEGAL: cover property (o_illegal);
	COV_PREDEC: cover property (acc_predec ##1 o_mem_rd_en);

endmodule : btu_core
`default_nettype wire

// ===== btu_pkg.sv
// shared constants, encodings and carrier types of the bit test unit
package btu_pkg;

	// opcode byte and field positions of the instruction word
	localparam int unsigned BTU_OPC_LSB = 16;
	localparam logic [7:0] BTU_OPC_MEM_TEST = 8'hAB;
	localparam logic [7:0] BTU_OPC_MEM_SET = 8'hAC;
	localparam logic [7:0] BTU_OPC_WREG_LIT = 8'hA3;
	localparam logic [7:0] BTU_OPC_WREG_IDX = 8'hA5;
	localparam int unsigned BTU_MEM_POS_LSB = 13;
	localparam int unsigned BTU_MEM_ADDR_LSB = 1;
	localparam int unsigned BTU_MEM_ADDR_MSB = 12;
	localparam int unsigned BTU_SHARED_POS = 0;
	localparam int unsigned BTU_LIT_POS_LSB = 12;
	localparam int unsigned BTU_LIT_DEST_POS = 11;
	localparam int unsigned BTU_IDX_DEST_POS = 15;
	localparam int unsigned BTU_IDX_REG_LSB = 11;
	localparam int unsigned BTU_MODE_LSB = 4;
	localparam int unsigned BTU_SRC_LSB = 0;

	// source addressing modes
	localparam logic [2:0] BTU_AM_DIRECT = 3'h0;
	localparam logic [2:0] BTU_AM_IND = 3'h1;
	localparam logic [2:0] BTU_AM_POSTINC = 3'h2;
	localparam logic [2:0] BTU_AM_POSTDEC = 3'h3;
	localparam logic [2:0] BTU_AM_PREINC = 3'h4;
	localparam logic [2:0] BTU_AM_PREDEC = 3'h5;
	localparam logic [15:0] BTU_PTR_STEP = 16'h0002;

	// flag positions, byte lanes and reset values
	localparam int unsigned BTU_FLAG_CARRY = 0;
	localparam int unsigned BTU_FLAG_NIL = 1;
	localparam logic [1:0] BTU_BE_WORD = 2'h3;
	localparam logic [1:0] BTU_BE_LO = 2'h1;
	localparam logic [1:0] BTU_BE_HI = 2'h2;
	localparam logic [15:0] BTU_FLAGS_RST = 16'h0000;
	localparam logic [15:0] BTU_WREG_RST = 16'h0000;

	// kind of instruction held in the execute stage
	typedef enum logic [1:0] {BTU_K_MEM_TEST, BTU_K_MEM_SET, BTU_K_WREG} btu_kind_t;

	// execute stage contents
	typedef struct packed {
		logic valid;
		btu_kind_t kind;
		logic [3:0] idx;
		logic byte_op;
		logic dest_nil;
		logic use_mem;
		logic [15:0] addr;
		logic [15:0] opnd;
	} btu_exec_t;

	// data memory write-back
	typedef struct packed {
		logic en;
		logic [15:0] addr;
		logic [15:0] data;
		logic [1:0] be;
	} btu_wr_t;

	// whole state of the unit
	typedef struct packed {
		logic [15:0][15:0] wreg;
		logic [15:0] flags;
		btu_exec_t ex;
		logic rd_en;
		logic [15:0] rd_addr;
		btu_wr_t wr;
		logic done;
		logic illegal;
		logic [15:0] wreg_rd;
	} btu_state_t;

	localparam btu_state_t BTU_STATE_RST = '0;

endpackage : btu_pkg

// ===== btu_bitsel.sv
// bit selection and bit setting on a word or byte operand
`timescale 1ns/1ps
`default_nettype none
module btu_bitsel (
	// operand and position
	input wire logic [15:0] i_word,
	input wire logic [3:0] i_idx,
	input wire logic i_byte_op,
	input wire logic i_byte_hi,
	// results
	output logic o_bit,
	output logic [15:0] o_set_word
);

	logic [3:0] pos;

	// byte positions 0..7 map into the lane picked by the address bit
	always_comb begin
		if (i_byte_op) begin
			pos = {i_byte_hi, i_idx[2:0]}; // [RQ5] [RQ7]
		end else begin
			pos = i_idx; // [RQ5]
		end
		o_bit = i_word[pos];
		o_set_word = i_word | (16'h0001 << pos); // [RQ16]
	end

endmodule : btu_bitsel
`default_nettype wire

// ===== btu_bench.sv
// self-checking bench of the bit test unit core
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e, m) begin check_count++; if ((g) !== (e)) begin n_mismatch++; $display("[FAIL] %0t %s", $time, m); end end
module btu_bench;
	logic clk, rst_n, instr_valid, byte_sfx, mem_wait, wr_en, fl_wr_en;
	logic [23:0] instr;
	logic [15:0] rd_data, wr_data, fl_wr_data, rd_addr, wreg_rd, flags, fl;
	logic [3:0] wr_sel, rd_sel;
	logic rd_en, done, illegal;
	btu_pkg::btu_wr_t mem_wr;
	logic [15:0] mem [0:4095];
	logic [15:0] wr [16];
	logic [31:0] seed, r;
	logic [12:0] a;
	logic [3:0] p;
	int n_mismatch, check_count, cyc, i;
	btu_core dut (.i_clk(clk), .i_rst_n(rst_n), .i_instr_valid(instr_valid), .i_instr(instr), .i_byte_sfx(byte_sfx),
		.o_mem_rd_en(rd_en), .o_mem_rd_addr(rd_addr), .i_mem_rd_data(rd_data), .i_mem_wait(mem_wait),
		.o_mem_wr(mem_wr), .i_wreg_wr_en(wr_en), .i_wreg_wr_sel(wr_sel), .i_wreg_wr_data(wr_data),
		.i_wreg_rd_sel(rd_sel), .o_wreg_rd_data(wreg_rd), .i_flags_wr_en(fl_wr_en), .i_flags_wr_data(fl_wr_data),
		.o_flags(flags), .o_done(done), .o_illegal(illegal));
	// memory answers only while read is requested, otherwise shows the inverse
	assign rd_data = rd_en ? mem[rd_addr[12:1]] : ~mem[rd_addr[12:1]];
	// xorshift source of random stimulus
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// expected address of the access (after=0) or pointer left behind (after=1), steps of two
	function automatic logic [15:0] exp_addr(input logic [2:0] md, input logic [15:0] p, input logic after);
		if (md == 3'h4 || (after && md == 3'h2)) return p + 16'h0002;
		if (md == 3'h5 || (after && md == 3'h3)) return p - 16'h0002;
		return p;
	endfunction : exp_addr
	// verdict and end of run
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask : tally_and_finish
	// load a working register and the model copy
	task automatic setreg(input logic [3:0] s, input logic [15:0] v);
		@(posedge clk) begin wr_en <= 1'b1; wr_sel <= s; wr_data <= v; end
		@(posedge clk) wr_en <= 1'b0;
		wr[s] = v;
	endtask : setreg
	// compare a working register through the readback port
	task automatic rdchk(input logic [3:0] s);
		@(posedge clk) rd_sel <= s;
		@(posedge clk) #1;
		`CHK(wreg_rd, wr[s], "register readback")
	endtask : rdchk
	// issue one instruction, check the read request and the completion time
	task automatic run(input logic [23:0] ins, input logic bs, input int nw, input logic rd, input logic [15:0] ea);
		int k;
		@(posedge clk) begin instr_valid <= 1'b1; instr <= ins; byte_sfx <= bs; mem_wait <= (nw > 0); end
		@(posedge clk) instr_valid <= 1'b0;
		#1;
		`CHK(rd_en, rd, "read request")
		if (rd) `CHK(rd_addr, ea, "read address")
		k = 0;
		while (done !== 1'b1 && k < 12) begin
			@(posedge clk);
			k++;
			if (k == nw) mem_wait <= 1'b0;
			#1;
		end
		`CHK(k, 1 + nw, "completion time")
		`CHK(illegal, 1'b0, "no refusal of a legal word")
	endtask : run
	// memory test or test-then-set with full expectation
	task automatic memop(input logic set, input logic bs, input logic [12:0] ad, input logic [3:0] ps, input int nw);
		logic [15:0] w;
		logic [3:0] ix;
		btu_pkg::btu_wr_t ew;
		w = mem[ad[12:1]];
		ix = bs ? {ad[0], ps[2:0]} : ps;
		fl[1] = ~w[ix];
		run(bs ? {set ? 8'hAC : 8'hAB, ps[2:0], ad} : {set ? 8'hAC : 8'hAB, ps[3:1], ad[12:1], ps[0]}, bs, nw, 1'b1,
			{3'h0, ad});
		`CHK(flags, fl, "nil flag after memory test")
		`CHK(mem_wr.en, set, "write enable")
		w[ix] = 1'b1;
		ew = '{en: 1'b1, addr: {3'h0, ad}, data: w, be: bs ? (ad[0] ? 2'h2 : 2'h1) : 2'h3};
		if (set) `CHK(mem_wr, ew, "set write-back")
		if (set) mem[ad[12:1]] = w;
	endtask : memop
	// working-register test, literal or register indexed
	task automatic wop(input logic idx, input logic dest, input logic [2:0] md, input logic [3:0] s, input logic [3:0] q);
		logic [15:0] ea, op, np;
		logic [3:0] ps;
		if (md != 3'h0) s[3] = 1'b0;
		if (idx && q == s) q = s ^ 4'h1;
		ps = idx ? wr[q][3:0] : q;
		ea = exp_addr(md, wr[s], 1'b0);
		np = exp_addr(md, wr[s], 1'b1);
		op = (md == 3'h0) ? wr[s] : mem[ea[12:1]];
		if (dest) fl[1] = ~op[ps];
		else fl[0] = op[ps];
		run(idx ? {8'hA5, dest, q, 3'h0, 1'b0, md, s} : {8'hA3, q, dest, 3'h0, 1'b0, md, s}, 1'b0, 0, md != 3'h0,
			ea);
		`CHK(flags, fl, "flag after register test")
		wr[s] = np;
		rdchk(s);
	endtask : wop
	// unknown opcode or addressing mode must be refused without effect
	task automatic bad(input logic [23:0] ins);
		int k;
		@(posedge clk) begin instr_valid <= 1'b1; instr <= ins; end
		@(posedge clk) instr_valid <= 1'b0;
		k = 0;
		#1;
		while (illegal !== 1'b1 && k < 3) begin @(posedge clk); #1; k++; end
		`CHK(illegal, 1'b1, "refusal flag")
		@(posedge clk) #1;
		`CHK(flags, fl, "flags kept on refusal")
	endtask : bad
	// clock of 25 ns period
	initial begin clk = 1'b0; forever #12.5 clk = ~clk; end
	// hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin n_mismatch++; $display("[FAIL] %0t run timed out", $time); tally_and_finish(); end
	end
	// main sequence
	initial begin
		{rst_n, instr_valid, byte_sfx, mem_wait, wr_en, fl_wr_en} = '0;
		{instr, wr_data, fl_wr_data, wr_sel, rd_sel} = '0;
		seed = 32'h00014CFC;
		for (i = 0; i < 4096; i++) mem[i] = rnd();
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		#1;
		`CHK(flags, 16'h0000, "flags after reset")
		wr = '{default: 16'h0000};
		rdchk(4'h3);
		$display("test reset done");
		for (i = 0; i < 16; i++) setreg(i, rnd() & (i < 8 ? 32'h00001FFE : 32'h0000FFFF));
		fl = rnd();
		@(posedge clk) begin fl_wr_en <= 1'b1; fl_wr_data <= fl; end
		@(posedge clk) fl_wr_en <= 1'b0;
		memop(1'b0, 1'b1, 13'h1FFF, 4'h7, 0);
		memop(1'b1, 1'b0, 13'h1FFE, 4'hF, 2);
		memop(1'b1, 1'b1, 13'h0000, 4'h0, 1);
		memop(1'b0, 1'b0, 13'h0000, 4'h0, 0);
		$display("test memory corners done");
		for (i = 0; i < 6; i++) begin
			wop(1'b0, i[0], i[2:0], i[3:0], 4'hF);
			wop(1'b1, ~i[0], i[2:0], i[3:0], 4'hC);
		end
		$display("test addressing modes done");
		r = rnd();
		fl[0] = wr[8][r[3:0]];
		fl[1] = ~wr[9][r[7:4]];
		@(posedge clk) begin instr_valid <= 1'b1; instr <= {8'hA3, r[3:0], 1'b0, 7'h00, 4'h8}; end
		@(posedge clk) instr <= {8'hA3, r[7:4], 1'b1, 7'h00, 4'h9};
		@(posedge clk) instr_valid <= 1'b0;
		#1;
		`CHK(done, 1'b1, "first of back-to-back")
		@(posedge clk) #1;
		`CHK(done, 1'b1, "second of back-to-back")
		`CHK(flags, fl, "flags after back-to-back")
		$display("test back-to-back done");
		for (i = 0; i < 150; i++) begin
			r = rnd();
			a = r[20:8];
			p = r[27:24];
			if (r[1]) p[3] = 1'b0;
			else a[0] = 1'b0;
			if (r[0]) memop(r[2], r[1], a, p, int'(r[30:29]));
			else wop(r[3], r[4], (r[7:5] > 3'h5) ? 3'h1 : r[7:5], r[15:12], r[19:16]);
		end
		$display("test random mix done");
		@(posedge clk) rst_n <= 1'b0;
		@(posedge clk) rst_n <= 1'b1;
		#1;
		`CHK(flags, 16'h0000, "flags after second reset")
		`CHK({done, illegal, rd_en, mem_wr.en}, 4'h0, "outputs after second reset")
		fl = 16'h0000;
		wr = '{default: 16'h0000};
		rdchk(r[3:0]);
		$display("test second reset done");
		bad(24'hA60000);
		bad({8'hA3, 4'h0, 1'b1, 7'h06, 4'h0});
		$display("test refusals done");
		tally_and_finish();
	end
endmodule : btu_bench
`default_nettype wire
